// File: bench/opvl_prog_model.sv
`timescale 1ns/1ps
`default_nettype none

// Programmer on the device pins; changes land just after a clock edge
module opvl_prog_model
	import opvl_pkg::*;
(
	input  wire logic       pclk,
	output var  opvl_pins_s pins
);
	// Address split over ports 1 and 2, mode on P2.6 P2.7 P3.6 P3.7
	function automatic opvl_pins_s frame(input logic [3:0] m, input logic [12:0] a, input logic [7:0] d,
		input logic vpp);
		frame = '{1'b1, 1'b0, 1'b1, 1'b1, vpp, d, a[7:0], {m[2], m[3], 1'b0, a[12:8]}, {m[0], m[1]}};
	endfunction : frame

	// Idle, out of program mode
	initial begin
		pins = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 2'b00};
	end

	// Inputs stay put across the whole pulse, one pulse per byte
	task automatic pgm_write(input logic [3:0] m, input logic [12:0] a, input logic [7:0] d);
		@(posedge pclk);
		pins <= frame(m, a, d, 1'b1);
		repeat (2) @(posedge pclk);
		pins.latch_strobe_program_pulse_n <= 1'b0;
		repeat (3) @(posedge pclk);
		pins.latch_strobe_program_pulse_n <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask : pgm_write

	// Port 0 released: inverse of the last value, so a stale byte never matches
	task automatic pgm_read(input logic [3:0] m, input logic [12:0] a);
		@(posedge pclk);
		pins <= frame(m, a, ~pins.port0, 1'b0);
		repeat (4) @(posedge pclk);
	endtask : pgm_read

	// Leave program mode with a given fetch select level
	task automatic pgm_leave(input logic ea);
		@(posedge pclk);
		pins.reset_pin <= 1'b0;
		pins.program_store_strobe_pin_n <= 1'b1;
		pins.external_fetch_select_pin <= ea;
	endtask : pgm_leave
endmodule : opvl_prog_model

`default_nettype wire

// File: bench/test_otp_program_verify_lock.sv
`timescale 1ns/1ps
`default_nettype none

`include "opvl_defines.svh"

module test_otp_program_verify_lock
	import opvl_pkg::*;
;
	localparam logic [7:0] SB0 = 8'h96; // Arbitrary value
	localparam logic [7:0] SB1 = 8'h69; // Arbitrary value
	localparam logic [7:0] SB2 = 8'h3E; // Arbitrary value

	typedef struct packed {
		logic [3:0]  m;
		logic [12:0] a;
		logic [7:0]  d;
	} opvl_row_s;

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	opvl_pins_s  pins;
	logic [7:0]  port0_out;
	logic        port0_oe;
	logic        ext_fetch_select_eff;
	logic        ext_exec_en;
	logic [31:0] rdat;
	logic        rerr;
	int          num_errors = 0;
	int          total_checks = 0;

	// Code rows first, they are programmed before the verify loop
	opvl_row_s rows [7] = '{
		'{`OPVL_MODE_RD_CODE, 13'h0000, 8'h3C},
		'{`OPVL_MODE_RD_CODE, 13'h1FFF, 8'hC5},
		'{`OPVL_MODE_RD_CODE, 13'h0A5A, 8'h00},
		'{`OPVL_MODE_SIG, `OPVL_SIG_ADDR0, SB0},
		'{`OPVL_MODE_SIG, `OPVL_SIG_ADDR1, SB1},
		'{`OPVL_MODE_SIG, `OPVL_SIG_ADDR2, SB2},
		'{`OPVL_MODE_SIG, 13'h0033, `OPVL_IDLE_BYTE}
	};

	opvl_top #(.SIG_BYTE0(SB0), .SIG_BYTE1(SB1), .SIG_BYTE2(SB2)) u_opvl_top (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pins(pins), .port0_out(port0_out), .port0_oe(port0_oe),
		.ext_fetch_select_eff(ext_fetch_select_eff), .ext_exec_en(ext_exec_en)
	);

	opvl_prog_model u_opvl_prog_model (.pclk(pclk), .pins(pins));

	// 20 MHz clock
	always #25 pclk = ~pclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Table read: start, check not busy, fetch result
	task automatic tbl(input logic [12:0] a, input logic ext);
		apb(1'b1, `OPVL_TBL_ADDR_OFS, {15'h0, ext, 3'h0, a});
		apb(1'b0, `OPVL_STATUS_OFS, 32'h0);
		chk({31'h0, rdat[`OPVL_ST_BUSY_BIT]}, 32'h0, "busy");
		apb(1'b0, `OPVL_TBL_DATA_OFS, 32'h0);
	endtask : tbl

	task automatic vfy(input logic [3:0] m, input logic [12:0] a, input logic [7:0] d);
		u_opvl_prog_model.pgm_read(m, a);
		#1 chk({23'h0, port0_oe, port0_out}, {23'h0, 1'b1, d}, "verify");
	endtask : vfy

	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	// Watchdog, well beyond the roughly 180 cycles the run needs
	initial begin
		repeat (5000) @(posedge pclk);
		num_errors++;
		end_of_test();
	end

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, `OPVL_STATUS_OFS, 32'hFFFF_FFFF);
		apb(1'b0, `OPVL_STATUS_OFS, 32'h0);
		chk(rdat, 32'h10, "status");
		apb(1'b0, 12'h00C, 32'h0);
		chk({rerr, rdat[30:0]}, 32'h8000_0000, "unmapped");
		foreach (rows[i]) if (rows[i].m == `OPVL_MODE_RD_CODE) u_opvl_prog_model.pgm_write(`OPVL_MODE_WR_CODE,
			rows[i].a, rows[i].d);
		foreach (rows[i]) vfy(rows[i].m, rows[i].a, rows[i].d);
		u_opvl_prog_model.pgm_leave(1'b1);
		tbl(13'h0000, 1'b1);
		chk(rdat, 32'h3C, "table unlocked");
		// Lock 1: code writes refused, fetch select frozen, external table reads blocked
		u_opvl_prog_model.pgm_write(`OPVL_MODE_LOCK1, 13'h0, 8'h00);
		u_opvl_prog_model.pgm_write(`OPVL_MODE_WR_CODE, 13'h0000, 8'h77);
		vfy(`OPVL_MODE_RD_CODE, 13'h0000, 8'h3C);
		u_opvl_prog_model.pgm_leave(1'b0);
		repeat (3) @(posedge pclk);
		#1 chk({31'h0, ext_fetch_select_eff}, 32'h1, "fetch select");
		tbl(13'h0000, 1'b1);
		chk(rdat, 32'h100, "table external");
		tbl(13'h0000, 1'b0);
		chk(rdat, 32'h3C, "table internal");
		apb(1'b0, `OPVL_STATUS_OFS, 32'h0);
		chk(rdat, 32'h19, "status lock1");
		u_opvl_prog_model.pgm_write(`OPVL_MODE_LOCK2, 13'h0, 8'h00);
		u_opvl_prog_model.pgm_read(`OPVL_MODE_RD_CODE, 13'h0000);
		#1 chk({31'h0, port0_oe}, 32'h0, "locked verify");
		u_opvl_prog_model.pgm_write(`OPVL_MODE_LOCK3, 13'h0, 8'h00);
		#1 chk({31'h0, ext_exec_en}, 32'h0, "exec enable");
		apb(1'b0, `OPVL_STATUS_OFS, 32'h0);
		chk(rdat, 32'h0F, "status lock3");
		// Second reset in mid-run clears the volatile lock bits
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `OPVL_STATUS_OFS, 32'h0);
		chk(rdat, 32'h18, "status reset");
		end_of_test();
	end
endmodule : test_otp_program_verify_lock

`default_nettype wire

// File: include/opvl_defines.svh
`ifndef OPVL_DEFINES_SVH
`define OPVL_DEFINES_SVH

// Register byte offsets on the APB side
`define OPVL_STATUS_OFS     12'h000
`define OPVL_TBL_ADDR_OFS   12'h004
`define OPVL_TBL_DATA_OFS   12'h008

// STATUS fields
`define OPVL_ST_LOCK_LSB    0
`define OPVL_ST_EA_BIT      3
`define OPVL_ST_EXEC_BIT    4
`define OPVL_ST_BUSY_BIT    5

// TABLE_ADDR and TABLE_DATA fields
`define OPVL_TA_EXT_BIT     16
`define OPVL_TD_BLOCK_BIT   8

// Mode pattern {P2.6, P2.7, P3.6, P3.7}
`define OPVL_MODE_WR_CODE   4'h7
`define OPVL_MODE_RD_CODE   4'h3
`define OPVL_MODE_LOCK1     4'hF
`define OPVL_MODE_LOCK2     4'hC
`define OPVL_MODE_LOCK3     4'hA
`define OPVL_MODE_SIG       4'h0

// Signature locations and reset values
`define OPVL_SIG_ADDR0      13'h0030
`define OPVL_SIG_ADDR1      13'h0031
`define OPVL_SIG_ADDR2      13'h0032
`define OPVL_LOCK_RESET     3'h0
`define OPVL_IDLE_BYTE      8'hFF

`endif

// File: include/opvl_pkg.sv
package opvl_pkg;

	typedef enum logic [0:0] {
		OPVL_ST_IDLE,
		OPVL_ST_PULSE
	} opvl_st_e;

	// Programmer pins, sampled synchronously to pclk
	typedef struct packed {
		logic       reset_pin;
		logic       program_store_strobe_pin_n;
		logic       latch_strobe_program_pulse_n;
		logic       external_fetch_select_pin;
		logic       vpp_high;
		logic [7:0] port0;
		logic [7:0] port1;
		logic [7:0] port2;
		logic [1:0] port3_hi;
	} opvl_pins_s;

	// Whole state of the top module
	typedef struct packed {
		opvl_st_e    st;
		logic        strobe_q;
		logic [3:0]  op;
		logic [12:0] wr_addr;
		logic [7:0]  wr_data;
		logic        mem_we;
		logic [2:0]  lock;
		logic        init_done;
		logic        ea_latch;
		logic        ea_eff;
		logic        ext_exec_en;
		logic        code_rd_q;
		logic        p0_code;
		logic [7:0]  p0_out;
		logic        p0_oe;
		logic [12:0] tbl_addr;
		logic        tbl_ext;
		logic        tbl_pend;
		logic        tbl_fetch;
		logic [7:0]  tbl_data;
		logic        tbl_blocked;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} opvl_state_s;

endpackage : opvl_pkg

// File: rtl/opvl_code_mem.sv
`timescale 1ns/1ps
`default_nettype none

// Code array, 8K bytes; read data leave through a register
module opvl_code_mem (
	input  wire logic        clk,
	input  wire logic        we,
	input  wire logic [12:0] waddr,
	input  wire logic [7:0]  wdata,
	input  wire logic [12:0] raddr,
	output var  logic [7:0]  rdata
);

	logic [7:0] mem [0:8191];

	// No reset on the array: it models nonvolatile storage
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end

endmodule : opvl_code_mem

`default_nettype wire

// File: rtl/opvl_top.sv
// Functional notes
// - Port 0 carries write data in, and read-back data out.
// - Operation decoded from P2.6, P2.7, P3.6, P3.7 levels.
// - Signature reads of 30H-32H return fixed identification bytes.
// - Three lock bits, unprogrammed at start, each set only by its own write.
// - No lock bits set means no restrictions at all.
// - Lock 1 stops table reads from external code returning internal bytes.
// - Lock 1 makes external fetch select latched at reset, later changes ignored.
// - Lock 1 refuses further code byte writes.
// - Lock 2 also disables code read verification.
// - Lock 3 also forbids execution from external program memory.
`timescale 1ns/1ps
`default_nettype none

`include "opvl_defines.svh"

module opvl_top
	import opvl_pkg::*;
#(
	parameter logic [7:0] SIG_BYTE0 = 8'hA5, // Arbitrary value
	parameter logic [7:0] SIG_BYTE1 = 8'h5A, // Arbitrary value
	parameter logic [7:0] SIG_BYTE2 = 8'hC3  // Arbitrary value
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire opvl_pins_s  pins,
	output var  logic [7:0]  port0_out,
	output var  logic        port0_oe,
	output var  logic        ext_fetch_select_eff,
	output var  logic        ext_exec_en
);

	opvl_state_s s;
	opvl_state_s s_next;

	logic [12:0] pin_addr;
	logic [3:0]  mode;
	logic        prog_mode;
	logic        rd_mode;
	logic        strobe;
	logic [12:0] mem_raddr;
	logic [7:0]  mem_rdata;
	logic        apb_acc;
	logic [7:0]  sig_byte;

	// Pin decode of address, mode and qualification
	assign pin_addr  = {pins.port2[4:0], pins.port1};
	assign mode      = {pins.port2[6], pins.port2[7], pins.port3_hi[0], pins.port3_hi[1]};
	assign prog_mode = pins.reset_pin & ~pins.program_store_strobe_pin_n;
	assign strobe    = pins.latch_strobe_program_pulse_n;
	assign rd_mode   = prog_mode & strobe & ~pins.vpp_high;
	assign apb_acc   = psel & penable & s.pready;

	// Programmer owns the array while in program mode, else table reads
	assign mem_raddr = prog_mode ? pin_addr : s.tbl_addr;

	// Fixed identification bytes, idle value elsewhere
	always_comb begin
		unique case (pin_addr)
			`OPVL_SIG_ADDR0: sig_byte = SIG_BYTE0;
			`OPVL_SIG_ADDR1: sig_byte = SIG_BYTE1;
			`OPVL_SIG_ADDR2: sig_byte = SIG_BYTE2;
			default:         sig_byte = `OPVL_IDLE_BYTE;
		endcase
	end

	opvl_code_mem u_mem (
		.clk   (pclk),
		.we    (s.mem_we),
		.waddr (s.wr_addr),
		.wdata (s.wr_data),
		.raddr (mem_raddr),
		.rdata (mem_rdata)
	);

	// Next-state logic for the whole block
	always_comb begin
		s_next          = s;
		s_next.strobe_q = strobe;
		s_next.mem_we   = 1'b0;

		// Strobe sequencer: capture on the fall, commit on the rise, so
		// the settled levels held across the pulse are the ones used
		unique case (s.st)
			OPVL_ST_IDLE: begin
				if (prog_mode && pins.vpp_high && s.strobe_q && !strobe) begin
					s_next.st      = OPVL_ST_PULSE;
					s_next.op      = mode;
					s_next.wr_addr = pin_addr;
					s_next.wr_data = pins.port0;
				end
			end
			OPVL_ST_PULSE: begin
				if (!prog_mode) begin
					s_next.st = OPVL_ST_IDLE; // Aborted pulse writes nothing
				end else if (strobe) begin
					s_next.st = OPVL_ST_IDLE;
					unique case (s.op)
						`OPVL_MODE_WR_CODE: s_next.mem_we  = ~s.lock[0];
						`OPVL_MODE_LOCK1:   s_next.lock[0] = 1'b1;
						`OPVL_MODE_LOCK2:   s_next.lock[1] = 1'b1;
						`OPVL_MODE_LOCK3:   s_next.lock[2] = 1'b1;
						default:            s_next.st      = OPVL_ST_IDLE;
					endcase
				end
			end
		endcase

		// Verify read: data leave the array one cycle after the address
		s_next.code_rd_q = rd_mode && (mode == `OPVL_MODE_RD_CODE) && !s.lock[1];
		// Code branch needs the read-code pattern now too, or a stale flag
		// from the previous cycle would show array data in signature mode
		if (s.code_rd_q && s_next.code_rd_q) begin
			s_next.p0_out  = mem_rdata;
			s_next.p0_oe   = 1'b1;
			s_next.p0_code = 1'b1;
		end else if (rd_mode && (mode == `OPVL_MODE_SIG)) begin
			s_next.p0_out  = sig_byte;
			s_next.p0_oe   = 1'b1;
			s_next.p0_code = 1'b0;
		end else begin
			s_next.p0_oe   = 1'b0; // Port released in every other mode
			s_next.p0_code = 1'b0;
		end

		// External fetch select is frozen at reset once lock 1 is set;
		// with it clear the pin passes straight through
		s_next.init_done = 1'b1;
		if (pins.reset_pin || !s.init_done) begin
			s_next.ea_latch = pins.external_fetch_select_pin;
		end
		s_next.ea_eff      = s.lock[0] ? s.ea_latch : pins.external_fetch_select_pin;
		s_next.ext_exec_en = ~s.lock[2];

		// Table read datapath, deferred while the programmer owns the array
		s_next.tbl_fetch = 1'b0;
		if (s.tbl_pend && !prog_mode) begin
			s_next.tbl_pend  = 1'b0;
			s_next.tbl_fetch = 1'b1;
		end
		if (s.tbl_fetch) begin
			s_next.tbl_data = mem_rdata;
		end

		// APB: one wait state, answer and data appear together
		s_next.pready  = psel && penable && !s.pready;
		s_next.pslverr = 1'b0;
		s_next.prdata  = 32'h0000_0000;
		if (psel && penable && !s.pready) begin
			unique case (paddr)
				`OPVL_STATUS_OFS: begin
					s_next.prdata[`OPVL_ST_LOCK_LSB +: 3] = s.lock;
					s_next.prdata[`OPVL_ST_EA_BIT]        = s.ea_eff;
					s_next.prdata[`OPVL_ST_EXEC_BIT]      = s.ext_exec_en;
					s_next.prdata[`OPVL_ST_BUSY_BIT]      = s.tbl_pend | s.tbl_fetch;
				end
				`OPVL_TBL_ADDR_OFS: begin
					s_next.prdata[12:0]              = s.tbl_addr;
					s_next.prdata[`OPVL_TA_EXT_BIT]  = s.tbl_ext;
				end
				`OPVL_TBL_DATA_OFS: begin
					s_next.prdata[7:0]                = s.tbl_data;
					s_next.prdata[`OPVL_TD_BLOCK_BIT] = s.tbl_blocked;
				end
				default: s_next.pslverr = 1'b1; // Unmapped address
			endcase
		end

		// Table read request from software takes effect on the access edge
		if (apb_acc && pwrite && (paddr == `OPVL_TBL_ADDR_OFS)) begin
			s_next.tbl_addr = pwdata[12:0];
			s_next.tbl_ext  = pwdata[`OPVL_TA_EXT_BIT];
			if (s.lock[0] && pwdata[`OPVL_TA_EXT_BIT]) begin
				s_next.tbl_blocked = 1'b1;
				s_next.tbl_data    = 8'h00;
				s_next.tbl_pend    = 1'b0;
			end else begin
				s_next.tbl_blocked = 1'b0;
				s_next.tbl_pend    = 1'b1;
			end
		end
	end

	// State register; lock bits come up unprogrammed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '{st: OPVL_ST_IDLE, lock: `OPVL_LOCK_RESET, strobe_q: 1'b1,
				ext_exec_en: 1'b1, p0_out: `OPVL_IDLE_BYTE, default: '0};
		end else begin
			s <= s_next;
		end
	end

	// Every output straight from the state register
	assign prdata               = s.prdata;
	assign pready               = s.pready;
	assign pslverr              = s.pslverr;
	assign port0_out            = s.p0_out;
	assign port0_oe             = s.p0_oe;
	assign ext_fetch_select_eff = s.ea_eff;
	assign ext_exec_en          = s.ext_exec_en;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Code write commits at the strobe rise when unlocked
	code_commit_a: assert property (
		(s.st == OPVL_ST_PULSE) && prog_mode && strobe && (s.op == `OPVL_MODE_WR_CODE) && !s.lock[0]
		|=> s.mem_we && (s.st == OPVL_ST_IDLE))
		else $error("code write not committed");

	// Locked array never written
	write_refuse_a: assert property (s.lock[0] |-> !s.mem_we)
		else $error("write while lock 1 set");

	// Lock bits only ever rise between resets
	lock_sticky_a: assert property ((($past(s.lock) & ~s.lock) == 3'h0))
		else $error("lock bit cleared");

	// Verify data never shown under lock 2
	verify_block_a: assert property (s.p0_oe && s.p0_code |-> !s.lock[1])
		else $error("code driven with verify disabled");

	// Signature byte appears one cycle after the request
	sig_value_a: assert property (
		rd_mode && (mode == `OPVL_MODE_SIG) && (pin_addr == `OPVL_SIG_ADDR0)
		|=> port0_oe && (port0_out == SIG_BYTE0))
		else $error("signature byte wrong");

	// Blocked table read returns nothing
	table_block_a: assert property (
		apb_acc && pwrite && (paddr == `OPVL_TBL_ADDR_OFS) && s.lock[0] && pwdata[`OPVL_TA_EXT_BIT]
		|=> s.tbl_blocked && (s.tbl_data == 8'h00) ##1 s.tbl_blocked)
		else $error("table read not blocked");

	// Latched select ignores the pin once locked
	ea_hold_a: assert property (
		s.lock[0] && $past(s.lock[0]) && s.init_done && !pins.reset_pin && !$past(pins.reset_pin)
		|=> $stable(s.ea_latch))
		else $error("fetch select not held");

	// Full lock stops external execution
	ext_exec_a: assert property ((s.lock == 3'h7) |=> !ext_exec_en[*2])
		else $error("external execution still enabled");

	// APB answers after exactly one wait state
	apb_wait_a: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
		else $error("APB answer timing wrong");

endmodule : opvl_top

`default_nettype wire
